// ---- verilog/comparator_ctrl_regs.sv ----
// Control and edge-flag registers for comparators one and two, mode register for comparator one
`timescale 1ns/1ps
module comparator_ctrl_regs (
  input wire logic clock, // 25 MHz system clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_page, // Current register page
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, registered
  input wire logic cmp_one_analog, // Raw comparator one level
  input wire logic cmp_two_analog, // Raw comparator two level
  output logic cmp_one_enable, // Comparator one power
  output logic cmp_two_enable, // Comparator two power
  output logic [1:0] cmp_one_pos_hysteresis, // Hysteresis+ code
  output logic [1:0] cmp_one_neg_hysteresis, // Hysteresis- code
  output logic [1:0] cmp_two_pos_hysteresis, // Hysteresis+ code
  output logic [1:0] cmp_two_neg_hysteresis, // Hysteresis- code
  output logic [1:0] cmp_one_response_mode, // Response-time mode
  output logic cmp_one_port_out, // Level for port routing
  output logic cmp_two_port_out, // Level for port routing
  output logic cmp_one_irq, // Interrupt request one
  output logic cmp_two_irq // Interrupt request two
);
  logic [7:0] ctl_one, ctl_two, mode_one;
  logic [7:0] next_ctl_one, next_ctl_two, next_mode_one, next_rdata;
  logic [1:0] sync_one, sync_two, next_sync_one, next_sync_two;
  logic [1:0] next_edge_one, next_edge_two;
  logic [1:0] stage_one, stage_two; // Stage 0 feeds stage 1 only
  logic hit_one_ctl, hit_one_mode, hit_two_ctl;
  logic rise_one, fall_one, rise_two, fall_two;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] p,
                               input logic [7:0] ea, input logic [7:0] ep);
    hit = (a == ea) && (p == ep);
  endfunction : hit

  assign hit_one_ctl = hit(reg_addr, reg_page, cmp_regs_pkg::ADDR_ONE_CONTROL,
                           cmp_regs_pkg::PAGE_ONE);
  assign hit_one_mode = hit(reg_addr, reg_page, cmp_regs_pkg::ADDR_ONE_MODE,
                            cmp_regs_pkg::PAGE_ONE);
  assign hit_two_ctl = hit(reg_addr, reg_page, cmp_regs_pkg::ADDR_TWO_CONTROL,
                           cmp_regs_pkg::PAGE_TWO);

  // ****************************************
  // Synchronisers and edge detect
  // ****************************************
  // Disabled comparator is held low, so power-down from a high level looks like one falling edge
  always_comb begin
    next_sync_one = {stage_one[0], cmp_one_analog & ctl_one[7]};
    next_sync_two = {stage_two[0], cmp_two_analog & ctl_two[7]};
    next_edge_one = {sync_one[0], stage_one[1]};
    next_edge_two = {sync_two[0], stage_two[1]};
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage_one <= 2'h0;
      stage_two <= 2'h0;
      sync_one <= 2'h0;
      sync_two <= 2'h0;
    end else begin
      stage_one <= next_sync_one;
      stage_two <= next_sync_two;
      sync_one <= next_edge_one;
      sync_two <= next_edge_two;
    end
  end

  assign rise_one = sync_one[0] & ~sync_one[1];
  assign fall_one = ~sync_one[0] & sync_one[1];
  assign rise_two = sync_two[0] & ~sync_two[1];
  assign fall_two = ~sync_two[0] & sync_two[1];

  // ****************************************
  // Register next values
  // ****************************************
  function automatic logic [7:0] ctl_next(input logic [7:0] cur,
      input logic wr, input logic [7:0] d, input logic lvl,
      input logic r, input logic f);
    logic [7:0] n;
    n = cur;
    if (wr) begin
      n = d;
    end
    n[cmp_regs_pkg::BIT_OUTPUT] = lvl;
    // Set beats a software clear in the same cycle
    n[cmp_regs_pkg::BIT_RISE] = n[cmp_regs_pkg::BIT_RISE] | r;
    n[cmp_regs_pkg::BIT_FALL] = n[cmp_regs_pkg::BIT_FALL] | f;
    ctl_next = n;
  endfunction : ctl_next

  always_comb begin
    next_ctl_one = ctl_next(ctl_one, reg_wr & hit_one_ctl, reg_wdata,
                            sync_one[0], rise_one, fall_one);
    next_ctl_two = ctl_next(ctl_two, reg_wr & hit_two_ctl, reg_wdata,
                            sync_two[0], rise_two, fall_two);
    next_mode_one = mode_one;
    if (reg_wr && hit_one_mode) begin
      next_mode_one = reg_wdata & cmp_regs_pkg::MODE_WRITE_MASK;
    end
    next_rdata = 8'h00;
    if (hit_one_ctl) begin
      next_rdata = ctl_one;
    end else if (hit_one_mode) begin
      next_rdata = mode_one;
    end else if (hit_two_ctl) begin
      next_rdata = ctl_two;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctl_one <= cmp_regs_pkg::RESET_CONTROL;
      ctl_two <= cmp_regs_pkg::RESET_CONTROL;
      mode_one <= cmp_regs_pkg::RESET_MODE;
      reg_rdata <= 8'h00;
    end else begin
      ctl_one <= next_ctl_one;
      ctl_two <= next_ctl_two;
      mode_one <= next_mode_one;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Outputs to analog core and interrupt
  // ****************************************
  assign cmp_one_enable = ctl_one[cmp_regs_pkg::BIT_ENABLE];
  assign cmp_two_enable = ctl_two[cmp_regs_pkg::BIT_ENABLE];
  assign cmp_one_pos_hysteresis = ctl_one[3:2];
  assign cmp_one_neg_hysteresis = ctl_one[1:0];
  assign cmp_two_pos_hysteresis = ctl_two[3:2];
  assign cmp_two_neg_hysteresis = ctl_two[1:0];
  assign cmp_one_response_mode = mode_one[1:0];
  assign cmp_one_port_out = ctl_one[cmp_regs_pkg::BIT_OUTPUT];
  assign cmp_two_port_out = ctl_two[cmp_regs_pkg::BIT_OUTPUT];
  // Comparator two mode register lives elsewhere; enables come in as ones
  assign cmp_one_irq = (ctl_one[cmp_regs_pkg::BIT_RISE] &
                        mode_one[cmp_regs_pkg::BIT_RISE_IE]) |
                       (ctl_one[cmp_regs_pkg::BIT_FALL] &
                        mode_one[cmp_regs_pkg::BIT_FALL_IE]);
  assign cmp_two_irq = ctl_two[cmp_regs_pkg::BIT_RISE] |
                       ctl_two[cmp_regs_pkg::BIT_FALL];

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_rise_seen;
    sync_one[0] && !sync_one[1];
  endsequence
  property p_rise_sets;
    @(posedge clock) disable iff (!nrst)
      s_rise_seen |=> ctl_one[5];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise lost");
  property p_fall_sets;
    @(posedge clock) disable iff (!nrst)
      (fall_two) |=> ctl_two[4];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall lost");
  property p_flag_holds;
    @(posedge clock) disable iff (!nrst)
      ctl_one[5] && !(reg_wr && hit_one_ctl) |=> ctl_one[5];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag drop");
  property p_mode_zero;
    @(posedge clock) disable iff (!nrst)
      (mode_one & 8'hCC) == 8'h00;
  endproperty
  a_mode_zero: assert property (p_mode_zero) else $error("mode bits");
  property p_mode_reset;
    @(posedge clock) !nrst |=> mode_one == 8'h02;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode rst");
  property p_page_two;
    @(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9A && reg_page != 8'h10 &&
      !rise_two && !fall_two |=>
      {ctl_two[7], ctl_two[5:0]} == $past({ctl_two[7], ctl_two[5:0]});
  endproperty
  a_page_two: assert property (p_page_two) else $error("page leak");
  property p_off_low;
    @(posedge clock) disable iff (!nrst)
      !cmp_one_enable ##1 !cmp_one_enable[*4] |-> !cmp_one_port_out;
  endproperty
  a_off_low: assert property (p_off_low) else $error("off not low");
  property p_irq;
    @(posedge clock) disable iff (!nrst)
      cmp_one_irq == ((ctl_one[5] && mode_one[5]) ||
                      (ctl_one[4] && mode_one[4]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_read_one;
    @(posedge clock) disable iff (!nrst)
      hit_one_ctl |=> reg_rdata == $past(ctl_one);
  endproperty
  a_read_one: assert property (p_read_one) else $error("read bad");

  // ****************************************
  // Further checks, both comparators
  // ****************************************
  // Edge and write sequences shared by the flag checks
  sequence s_fall_one;
    !sync_one[0] && sync_one[1];
  endsequence
  sequence s_rise_two;
    sync_two[0] && !sync_two[1];
  endsequence
  sequence s_no_ctl_one_write;
    !(reg_wr && hit_one_ctl);
  endsequence
  sequence s_no_ctl_two_write;
    !(reg_wr && hit_two_ctl);
  endsequence

  property p_fall_one_sets;
    @(posedge clock) disable iff (!nrst)
      s_fall_one |=> ctl_one[cmp_regs_pkg::BIT_FALL];
  endproperty
  a_fall_one_sets: assert property (p_fall_one_sets)
    else $error("fall one lost");

  property p_rise_two_sets;
    @(posedge clock) disable iff (!nrst)
      s_rise_two |=> ctl_two[cmp_regs_pkg::BIT_RISE];
  endproperty
  a_rise_two_sets: assert property (p_rise_two_sets)
    else $error("rise two lost");

  // Only a software write may clear a flag
  property p_fall_holds;
    @(posedge clock) disable iff (!nrst)
      ctl_one[cmp_regs_pkg::BIT_FALL] ##0 s_no_ctl_one_write |=>
      ctl_one[cmp_regs_pkg::BIT_FALL];
  endproperty
  a_fall_holds: assert property (p_fall_holds)
    else $error("fall flag drop");

  property p_two_flag_holds;
    @(posedge clock) disable iff (!nrst)
      ctl_two[cmp_regs_pkg::BIT_RISE] ##0 s_no_ctl_two_write |=>
      ctl_two[cmp_regs_pkg::BIT_RISE];
  endproperty
  a_two_flag_holds: assert property (p_two_flag_holds)
    else $error("two flag drop");

  property p_out_one;
    @(posedge clock) disable iff (!nrst)
      1'b1 |=> ctl_one[cmp_regs_pkg::BIT_OUTPUT] == $past(sync_one[0]);
  endproperty
  a_out_one: assert property (p_out_one)
    else $error("output one stale");

  property p_out_two;
    @(posedge clock) disable iff (!nrst)
      1'b1 |=> ctl_two[cmp_regs_pkg::BIT_OUTPUT] == $past(sync_two[0]);
  endproperty
  a_out_two: assert property (p_out_two)
    else $error("output two stale");

  property p_write_one;
    @(posedge clock) disable iff (!nrst)
      reg_wr && hit_one_ctl |=>
      {ctl_one[7], ctl_one[3:0]} == $past({reg_wdata[7], reg_wdata[3:0]});
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("control one write");

  property p_write_two;
    @(posedge clock) disable iff (!nrst)
      reg_wr && hit_two_ctl |=>
      {ctl_two[7], ctl_two[3:0]} == $past({reg_wdata[7], reg_wdata[3:0]});
  endproperty
  a_write_two: assert property (p_write_two)
    else $error("control two write");

  property p_mode_write;
    @(posedge clock) disable iff (!nrst)
      reg_wr && hit_one_mode |=>
      {mode_one[5:4], mode_one[1:0]} ==
      $past({reg_wdata[5:4], reg_wdata[1:0]});
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write");

  property p_read_mode;
    @(posedge clock) disable iff (!nrst)
      hit_one_mode |=> reg_rdata == $past(mode_one);
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("read mode");

  property p_read_two;
    @(posedge clock) disable iff (!nrst)
      hit_two_ctl |=> reg_rdata == $past(ctl_two);
  endproperty
  a_read_two: assert property (p_read_two) else $error("read two");

  // Unmapped address or wrong page reads as zero
  property p_read_none;
    @(posedge clock) disable iff (!nrst)
      !hit_one_ctl && !hit_one_mode && !hit_two_ctl |=> reg_rdata == 8'h00;
  endproperty
  a_read_none: assert property (p_read_none) else $error("read leak");

  property p_off_low_two;
    @(posedge clock) disable iff (!nrst)
      !cmp_two_enable ##1 !cmp_two_enable[*4] |-> !cmp_two_port_out;
  endproperty
  a_off_low_two: assert property (p_off_low_two)
    else $error("off two not low");

  property p_irq_two;
    @(posedge clock) disable iff (!nrst)
      cmp_two_irq == (ctl_two[5] || ctl_two[4]);
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("irq two");

  // One transition gives a one-cycle edge pulse, never two
  property p_one_pulse;
    @(posedge clock) disable iff (!nrst)
      rise_one |=> !rise_one;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("double edge");
endmodule : comparator_ctrl_regs

// ---- inc/cmp_regs_pkg.sv ----
// Constants for the two-comparator control register bank
// How it works
// - Control register: enable, output, rise flag, fall flag, hyst+ [3:2], hyst- [1:0].
// - Output state bit is read-only; 1 when positive input exceeds negative.
// - Rise flag sets on rising edge, holds until software writes zero.
// - Fall flag sets on falling edge, holds until software writes zero.
// - Positive hysteresis code goes to the analog core: off, 5, 10, 20 mV.
// - Negative hysteresis code goes to the analog core with the same codes.
// - Mode register bit 5 enables rising-edge interrupts.
// - Mode register bit 4 enables falling-edge interrupts.
// - Two-bit response mode goes to the core; resets to 10.
// - Mode register bits 7:6 and 3:2 read zero, writes ignored.
// - Comparator one control decodes at 0x9D on page 0x00.
// - Comparator one mode decodes at 0x9E on page 0x00.
// - Comparator two control decodes at 0x9A only on page 0x10.
// - Output transitions set the matching rise or fall flag.
// - Disabled comparator drives routed output low and powers down.
package cmp_regs_pkg;
  localparam logic [7:0] ADDR_ONE_CONTROL = 8'h9D;
  localparam logic [7:0] ADDR_ONE_MODE = 8'h9E;
  localparam logic [7:0] ADDR_TWO_CONTROL = 8'h9A;
  localparam logic [7:0] PAGE_ONE = 8'h00;
  localparam logic [7:0] PAGE_TWO = 8'h10;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_OUTPUT = 6;
  localparam int BIT_RISE = 5;
  localparam int BIT_FALL = 4;
  localparam int BIT_RISE_IE = 5;
  localparam int BIT_FALL_IE = 4;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MODE = 8'h02;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h33;
endpackage : cmp_regs_pkg

// ---- tb/cmp_core_model.sv ----
// Analog comparator core stand-in supplying the raw output level
`timescale 1ns/1ps
module cmp_core_model (
  input wire logic clock, // System clock
  input wire logic powered, // Enable from the register bank
  input wire logic level_cmd, // Level asked for by the bench
  output logic level // Raw comparator output
);
  initial level = 1'b0;
  // Powered off the level means nothing, so keep it moving
  always @(posedge clock) begin
    if (powered) begin
      level <= level_cmd;
    end else begin
      level <= ~level;
    end
  end
endmodule : cmp_core_model

// ---- tb/comparator_ctrl_regs_tb.sv ----
// Register-level bench for the comparator control register bank
`timescale 1ns/1ps
module comparator_ctrl_regs_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_page = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic lvl_one = 1'b0;
  logic lvl_two = 1'b0;
  logic a_one, a_two, en_one, en_two, po_one, po_two, irq_one, irq_two;
  logic [1:0] hp_one, hn_one, hp_two, hn_two, mode_one;
  logic [7:0] reg_rdata;
  int mismatches = 0;
  int compares = 0;
  always #20 clock = ~clock;
  comparator_ctrl_regs u_comparator_ctrl_regs (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_page(reg_page), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_one_analog(a_one),
    .cmp_two_analog(a_two), .cmp_one_enable(en_one), .cmp_two_enable(en_two),
    .cmp_one_pos_hysteresis(hp_one), .cmp_one_neg_hysteresis(hn_one),
    .cmp_two_pos_hysteresis(hp_two), .cmp_two_neg_hysteresis(hn_two),
    .cmp_one_response_mode(mode_one), .cmp_one_port_out(po_one),
    .cmp_two_port_out(po_two), .cmp_one_irq(irq_one), .cmp_two_irq(irq_two));
  cmp_core_model u_cmp_core_model_one (.clock(clock), .powered(en_one),
    .level_cmd(lvl_one), .level(a_one));
  cmp_core_model u_cmp_core_model_two (.clock(clock), .powered(en_two),
    .level_cmd(lvl_two), .level(a_two));
  // ***********************************************
  // Access tasks
  // ***********************************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, p, d);
    @(negedge clock);
    reg_addr = a;
    reg_page = p;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, p, exp);
    @(negedge clock);
    reg_addr = a;
    reg_page = p;
    @(negedge clock);
    check($sformatf("reg %h page %h", a, p), reg_rdata, exp);
  endtask : rd
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Run is about 130 cycles; anything longer is a hang
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    rd(8'h9D, 8'h00, 8'h00);
    rd(8'h9E, 8'h00, 8'h02);
    rd(8'h9A, 8'h10, 8'h00);
    rd(8'h9A, 8'h00, 8'h00);
    $display("test reset values done");
    wr(8'h9E, 8'h00, 8'hFF);
    rd(8'h9E, 8'h00, 8'h33);
    for (int i = 0; i < 4; i++) begin
      wr(8'h9E, 8'h00, 8'(i));
      check("mode", {6'h00, mode_one}, 8'(i));
      wr(8'h9D, 8'h00, 8'(i * 3 + 3));
      check("hyst one", {4'h0, hp_one, hn_one}, 8'(i * 3 + 3));
      wr(8'h9A, 8'h10, 8'(12 - i * 3));
      check("hyst two", {4'h0, hp_two, hn_two}, 8'(12 - i * 3));
    end
    wr(8'h9A, 8'h00, 8'h80);
    check("two enable", {7'h00, en_two}, 8'h00);
    $display("test fields done");
    wr(8'h9E, 8'h00, 8'h20);
    wr(8'h9D, 8'h00, 8'h80);
    repeat (6) @(negedge clock);
    wr(8'h9D, 8'h00, 8'h80);
    lvl_one = 1'b1;
    repeat (6) @(negedge clock);
    rd(8'h9D, 8'h00, 8'hE0);
    check("irq one", {7'h00, irq_one}, 8'h01);
    check("port one", {7'h00, po_one}, 8'h01);
    wr(8'h9D, 8'h00, 8'hC0);
    rd(8'h9D, 8'h00, 8'hC0);
    lvl_one = 1'b0;
    repeat (6) @(negedge clock);
    rd(8'h9D, 8'h00, 8'h90);
    rd(8'h9D, 8'h10, 8'h00);
    check("irq one", {7'h00, irq_one}, 8'h00);
    wr(8'h9E, 8'h00, 8'h10);
    @(negedge clock);
    check("irq one", {7'h00, irq_one}, 8'h01);
    wr(8'h9D, 8'h00, 8'h00);
    repeat (6) @(negedge clock);
    check("port one", {7'h00, po_one}, 8'h00);
    check("enable one", {7'h00, en_one}, 8'h00);
    $display("test comparator one edges done");
    wr(8'h9A, 8'h10, 8'h80);
    repeat (6) @(negedge clock);
    wr(8'h9A, 8'h10, 8'h80);
    lvl_two = 1'b1;
    repeat (6) @(negedge clock);
    rd(8'h9A, 8'h10, 8'hE0);
    check("irq two", {7'h00, irq_two}, 8'h01);
    wr(8'h9A, 8'h10, 8'h00);
    repeat (6) @(negedge clock);
    check("port two", {7'h00, po_two}, 8'h00);
    rd(8'h9A, 8'h10, 8'h10);
    check("irq two", {7'h00, irq_two}, 8'h01);
    $display("test comparator two edges done");
    @(negedge clock);
    nrst = 1'b0;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    rd(8'h9E, 8'h00, 8'h02);
    rd(8'h9A, 8'h10, 8'h00);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : comparator_ctrl_regs_tb
